//--- design/pcp_params.svh
`ifndef PCP_PARAMS_SVH
`define PCP_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define PCP_OFF_STATUS   12'h014
`define PCP_OFF_UNLOCK   12'h018
`define PCP_OFF_LOOP     12'h024
`define PCP_OFF_FP_CTRL  12'h030
`define PCP_OFF_FP_MUL   12'h034
`define PCP_OFF_FP_DIV   12'h038
`define PCP_OFF_GCLK     12'h074
`define PCP_OFF_VERSION  12'h3cc
`define PCP_GCLK_STRIDE  12'h004

// Key byte that opens the loop control register for one write.
`define PCP_UNLOCK_KEY   8'haa

// AXI response codes.
`define PCP_RESP_OKAY    2'h0
`define PCP_RESP_SLVERR  2'h2

// Identification values; both are arbitrary.
`define PCP_VERSION_NUM  12'h100
`define PCP_VARIANT_NUM  4'h0

// Positions of the lock oscillator and loop output in the sampled inputs.
`define PCP_IN_SYSTEM_RC_OSCILLATOR     4
`define PCP_IN_VCO       5

// Reset values; the loop control word starts with the loop off.
`define PCP_LOOP_RESET   32'h0000_0000
`define PCP_FP_MUL_RESET 16'h0001
`define PCP_FP_DIV_RESET 16'h0001

`endif

//--- design/pcp_pkg.sv
package pcp_pkg;

  // Loop control word; pad fields keep reserved bits at zero.
  typedef struct packed {
    logic [1:0] pad3;
    logic [5:0] count;
    logic [3:0] pad2;
    logic [3:0] mul;
    logic [3:0] pad1;
    logic [3:0] div;
    logic [1:0] pad0;
    logic [2:0] opt;
    logic [1:0] osc;
    logic       en;
  } pcp_loop_t;

  // Generic clock control word.
  typedef struct packed {
    logic [7:0]  pad1;
    logic [7:0]  div;
    logic [11:0] pad0;
    logic [1:0]  src;
    logic        div_en;
    logic        en;
  } pcp_gclk_t;

  // Fractional prescaler control word.
  typedef struct packed {
    logic [28:0] pad0;
    logic [1:0]  sel;
    logic        en;
  } pcp_fp_t;

  // Status word.
  typedef struct packed {
    logic [28:0] pad0;
    logic        unlocked;
    logic        power;
    logic        lock;
  } pcp_status_t;

  // Version word.
  typedef struct packed {
    logic [11:0] pad1;
    logic [3:0]  variant;
    logic [3:0]  pad0;
    logic [11:0] version;
  } pcp_version_t;

  typedef enum logic [2:0] {
    PCP_OFF    = 3'b001,
    PCP_WAIT   = 3'b010,
    PCP_LOCKED = 3'b100
  } pcp_lock_state_t;

  // Merges a written word into an old one under the byte strobes.
  function automatic logic [31:0] pcp_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction : pcp_merge

endpackage : pcp_pkg

//--- design/pcp_clock_ctrl.sv
// Function
// - Loop stays off after reset until enabled.
// - Power-on or reconfiguration makes loop unlocked.
// - Loop clock output masked while not locked.
// - Loop control writes need prior unlock sequence.
// - Prescaler output is source times mult over 2div.
// - Source select fixed while running; ratios change live.
// - Half periods whole source periods, differ by at most one.
// - Non-integer ratio yields jitter from unequal halves.
// - Generic clock: selectable source, even divide up to 512.
// - Generic clocks enable individually, stop during sleep.
// - Lock flag after programmed RC cycles from restart.
// - Loop ratio (mul+1)/div, or 2(mul+1) for zero.
// - Option bit zero selects oscillator range.
// - Option bit one halves loop output.
// - Option bit two inverted wide-bandwidth control.
// - Oscillator select picks loop reference source.
// - Version register read-only, version and variant.
`include "pcp_params.svh"

module pcp_clock_ctrl
  import pcp_pkg::*;
#(
  parameter int NUM_GCLK = 4,
  parameter int FP_W     = 16
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [11:0]         awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [11:0]         araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire logic [3:0]          src_clk,
  input  wire logic                system_rc_oscillator_clk,
  input  wire logic                loop_vco_clk,
  input  wire logic                sleep_active,
  input  wire logic                periph_clk_stop,
  output logic                     loop_power_on,
  output logic [1:0]               loop_ref_select,
  output logic                     loop_range_high,
  output logic                     loop_wideband_en,
  output logic [5:0]               loop_ratio_num,
  output logic [3:0]               loop_ratio_den,
  output logic                     loop_clk_out,
  output logic                     lock_status_flag,
  output logic                     frac_prescaled_clock_out,
  output wire logic [NUM_GCLK-1:0] gclk_out
);

  default clocking pcp_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  localparam int NIN = 6;

  // Register address of generic clock g.
  function automatic logic [11:0] pcp_gclk_addr(input int g);
    return `PCP_OFF_GCLK + 12'(g) * `PCP_GCLK_STRIDE;
  endfunction : pcp_gclk_addr

  // True for every address the slave decodes.
  function automatic logic pcp_known(input logic [11:0] a);
    logic hit;
    hit = (a == `PCP_OFF_STATUS) || (a == `PCP_OFF_UNLOCK) ||
          (a == `PCP_OFF_LOOP) || (a == `PCP_OFF_FP_CTRL) ||
          (a == `PCP_OFF_FP_MUL) || (a == `PCP_OFF_FP_DIV) ||
          (a == `PCP_OFF_VERSION);
    for (int g = 0; g < NUM_GCLK; g++) begin
      if (a == pcp_gclk_addr(g)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : pcp_known

  // Every clock arriving from outside passes two flops; a third one
  // gives the edge detectors a clean delayed copy. Sampling at aclk
  // means the sources must run well below half the aclk rate.
  logic [NIN-1:0] in_raw;
  logic [NIN-1:0] in_s1;
  logic [NIN-1:0] in_s2;
  logic [NIN-1:0] in_s3;
  logic [NIN-1:0] in_rise;
  assign in_raw  = {loop_vco_clk, system_rc_oscillator_clk, src_clk};
  assign in_rise = in_s2 & ~in_s3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_s1 <= '0;
      in_s2 <= '0;
      in_s3 <= '0;
    end else begin
      in_s1 <= in_raw;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
    end
  end

  // Bus slave state. An address or data beat is held while its ready
  // is low and no response is pending.
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        aw_full;
  logic        w_full;
  logic        do_write;
  logic        unlocked;
  logic        loop_wr_hit;
  logic        loop_wr_ok;
  logic        unlock_ok;
  logic [31:0] wr_merged;
  assign aw_full     = !awready && !bvalid;
  assign w_full      = !wready && !bvalid;
  assign do_write    = aw_full && w_full;
  assign loop_wr_hit = do_write && (wr_addr == `PCP_OFF_LOOP);
  assign loop_wr_ok  = loop_wr_hit && unlocked;
  assign unlock_ok   = do_write && (wr_addr == `PCP_OFF_UNLOCK) &&
                       (wr_data[31:24] == `PCP_UNLOCK_KEY) &&
                       (wr_data[11:0] == `PCP_OFF_LOOP);

  // Write channels are taken in either order; the response follows both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `PCP_RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready  <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= (!pcp_known(wr_addr) || (loop_wr_hit && !unlocked)) ?
                  `PCP_RESP_SLVERR : `PCP_RESP_OKAY;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // The key opens exactly one following write; any other write closes it,
  // so a runaway store cannot reach the loop configuration.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlocked <= 1'b0;
    end else if (do_write) begin
      unlocked <= unlock_ok;
    end
  end

  // Loop control register and restart request.
  pcp_loop_t loop_q;
  pcp_loop_t loop_wr;
  logic      restart_q;
  logic      sleep_d;
  logic      sleep_fall;
  logic      loop_active;
  assign wr_merged   = pcp_merge(loop_q, wr_data, wr_strb);
  assign loop_wr     = pcp_loop_t'(wr_merged);
  assign sleep_fall  = sleep_d && !sleep_active;
  assign loop_active = loop_q.en && !sleep_active;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_q    <= pcp_loop_t'(`PCP_LOOP_RESET);
      restart_q <= 1'b0;
      sleep_d   <= 1'b0;
    end else begin
      if (loop_wr_ok) begin
        loop_q <= '{count: loop_wr.count, mul: loop_wr.mul,
                    div: loop_wr.div, opt: loop_wr.opt,
                    osc: loop_wr.osc, en: loop_wr.en, default: '0};
      end
      restart_q <= loop_wr_ok || sleep_fall;
      sleep_d   <= sleep_active;
    end
  end

  // Lock sequencer counting rising edges of the system RC oscillator.
  // The restart request one cycle after a configuration write wins over a lock completing in its cycle,
  // since the loop must relock after any change.
  pcp_lock_state_t lock_state;
  pcp_lock_state_t next_lock_state;
  logic [5:0]      lock_cnt;
  logic [5:0]      next_lock_cnt;
  logic            rc_rise;
  assign rc_rise = in_rise[`PCP_IN_SYSTEM_RC_OSCILLATOR];

  always_comb begin
    next_lock_state = lock_state;
    next_lock_cnt   = lock_cnt;
    if (!loop_active) begin
      next_lock_state = PCP_OFF;
      next_lock_cnt   = '0;
    end else if (restart_q) begin
      next_lock_state = PCP_WAIT;
      next_lock_cnt   = '0;
    end else begin
      case (lock_state)
        PCP_OFF: begin
          next_lock_state = PCP_WAIT;
        end
        PCP_WAIT: begin
          if (lock_cnt == loop_q.count) begin
            next_lock_state = PCP_LOCKED;
          end else if (rc_rise) begin
            next_lock_cnt = lock_cnt + 6'h01;
          end
        end
        PCP_LOCKED: begin
          next_lock_state = PCP_LOCKED;
        end
        default: begin
          next_lock_state = PCP_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_state <= PCP_OFF;
      lock_cnt   <= '0;
    end else begin
      lock_state <= next_lock_state;
      lock_cnt   <= next_lock_cnt;
    end
  end

  // Loop controls toward the analog loop. Software must set the ratio
  // and options before the enable and keep the multiplier above one.
  logic vco_half;
  logic vco_sel;
  logic lock_next;
  assign vco_sel   = loop_q.opt[1] ? vco_half : in_s2[`PCP_IN_VCO];
  assign lock_next = (next_lock_state == PCP_LOCKED);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_power_on    <= 1'b0;
      loop_ref_select  <= '0;
      loop_range_high  <= 1'b0;
      loop_wideband_en <= 1'b1;
      loop_ratio_num   <= 6'h02;
      loop_ratio_den   <= 4'h1;
      vco_half         <= 1'b0;
      loop_clk_out     <= 1'b0;
      lock_status_flag <= 1'b0;
    end else begin
      loop_power_on    <= loop_active;
      loop_ref_select  <= loop_q.osc;
      loop_range_high  <= loop_q.opt[0];
      loop_wideband_en <= !loop_q.opt[2];
      loop_ratio_num   <= (loop_q.div == 4'h0) ?
                          {2'(({1'b0, loop_q.mul} + 5'h01) >> 4),
                           loop_q.mul + 4'h1} << 1 :
                          6'({1'b0, loop_q.mul} + 5'h01);
      loop_ratio_den   <= (loop_q.div == 4'h0) ? 4'h1 : loop_q.div;
      vco_half         <= in_rise[`PCP_IN_VCO] ? !vco_half : vco_half;
      loop_clk_out     <= lock_next && vco_sel;
      lock_status_flag <= lock_next;
    end
  end

  loop_off_a: assert property (!loop_q.en |=> !loop_power_on)
    else $error("loop powered without enable");
  unlock_restart_a: assert property (loop_wr_ok |=> ##1 !lock_status_flag)
    else $error("lock flag held across reconfiguration");
  clk_masked_a: assert property (!lock_status_flag |-> !loop_clk_out)
    else $error("loop clock passed while unlocked");
  protect_reject_a: assert property (loop_wr_hit && !unlocked |=>
    $stable(loop_q) && bresp == `PCP_RESP_SLVERR)
    else $error("protected write not rejected");
  lock_count_a: assert property (lock_state == PCP_WAIT && loop_active &&
    !restart_q && lock_cnt == loop_q.count |=> lock_status_flag)
    else $error("lock flag late after count");
  ratio_zero_a: assert property (loop_q.div == 4'h0 ##1
    loop_q.div == 4'h0 |-> loop_ratio_den == 4'h1 && !loop_ratio_num[0])
    else $error("zero divider ratio wrong");
  wideband_a: assert property (
    loop_wideband_en == !$past(loop_q.opt[2]))
    else $error("wide bandwidth sense wrong");
  lock_seen_c: cover property (restart_q ##[1:200] lock_status_flag);

  // Fractional prescaler: a phase accumulator adds the multiplier on each
  // source edge and toggles the output when it passes the divider, so
  // each half period is a whole number of source periods and the two
  // halves differ by at most one; ratios that are not integers jitter.
  pcp_fp_t         fp_q;
  pcp_fp_t         fp_wr;
  logic [FP_W-1:0] fp_mul;
  logic [FP_W-1:0] fp_div;
  logic [FP_W-1:0] fp_acc;
  logic [FP_W:0]   fp_sum;
  logic            fp_wrap;
  logic            fp_rise;
  assign fp_wr   = pcp_fp_t'(pcp_merge(fp_q, wr_data, wr_strb));
  assign fp_rise = in_rise[fp_q.sel];
  assign fp_sum  = {1'b0, fp_acc} + {1'b0, fp_mul};
  assign fp_wrap = fp_sum >= {1'b0, fp_div};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fp_q   <= '0;
      fp_mul <= `PCP_FP_MUL_RESET;
      fp_div <= `PCP_FP_DIV_RESET;
    end else if (do_write) begin
      if (wr_addr == `PCP_OFF_FP_CTRL) begin
        fp_q.en <= fp_wr.en;
        if (!fp_q.en) begin
          fp_q.sel <= fp_wr.sel;
        end
      end
      if (wr_addr == `PCP_OFF_FP_MUL) begin
        fp_mul <= FP_W'(pcp_merge(32'(fp_mul), wr_data, wr_strb));
      end
      if (wr_addr == `PCP_OFF_FP_DIV) begin
        fp_div <= FP_W'(pcp_merge(32'(fp_div), wr_data, wr_strb));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fp_acc                   <= '0;
      frac_prescaled_clock_out <= 1'b0;
    end else if (!fp_q.en) begin
      fp_acc                   <= '0;
      frac_prescaled_clock_out <= 1'b0;
    end else if (fp_rise) begin
      fp_acc <= fp_wrap ? FP_W'(fp_sum - {1'b0, fp_div}) : fp_sum[FP_W-1:0];
      if (fp_wrap) begin
        frac_prescaled_clock_out <= !frac_prescaled_clock_out;
      end
    end
  end

  frac_toggle_a: assert property (fp_q.en && fp_rise && fp_wrap |=>
    frac_prescaled_clock_out != $past(frac_prescaled_clock_out))
    else $error("prescaler missed a toggle");
  frac_sel_a: assert property (fp_q.en |=> $stable(fp_q.sel))
    else $error("prescaler source changed while running");
  frac_toggle_c: cover property (fp_q.en && fp_rise && fp_wrap);

  // Generic clocks. Each toggles after div+1 source edges, giving any even
  // ratio from 2 to 512; with the divider off it copies the source level.
  logic [31:0] gclk_word [NUM_GCLK];

  for (genvar g = 0; g < NUM_GCLK; g++) begin : g_gclk
    pcp_gclk_t  cfg;
    pcp_gclk_t  cfg_wr;
    logic [7:0] cnt;
    logic       out;
    logic       run;
    logic       rise;
    logic       wrap;
    assign cfg_wr       = pcp_gclk_t'(pcp_merge(cfg, wr_data, wr_strb));
    assign run          = cfg.en && !periph_clk_stop;
    assign rise         = in_rise[cfg.src];
    assign wrap         = (cnt == cfg.div);
    assign gclk_word[g] = cfg;
    assign gclk_out[g]  = out;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg <= '0;
      end else if (do_write && wr_addr == pcp_gclk_addr(g)) begin
        cfg <= '{div: cfg_wr.div, src: cfg_wr.src, div_en: cfg_wr.div_en,
                 en: cfg_wr.en, default: '0};
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
        cnt <= '0;
        out <= 1'b0;
      end else if (!cfg.div_en) begin
        out <= in_s2[cfg.src];
      end else if (rise) begin
        cnt <= wrap ? 8'h00 : cnt + 8'h01;
        out <= wrap ? !out : out;
      end
    end

    gclk_sleep_a: assert property (periph_clk_stop |=> !out)
      else $error("generic clock ran during sleep");
    gclk_toggle_c: cover property (run && cfg.div_en && rise && wrap);
  end

  // Read path: one cycle from address to data.
  pcp_status_t  status_word;
  pcp_version_t version_word;
  logic [31:0]  rd_word;
  assign status_word  = '{lock: lock_status_flag, power: loop_power_on,
                          unlocked: unlocked, default: '0};
  assign version_word = '{version: `PCP_VERSION_NUM,
                          variant: `PCP_VARIANT_NUM, default: '0};

  always_comb begin
    rd_word = '0;
    case (araddr)
      `PCP_OFF_STATUS:  rd_word = status_word;
      `PCP_OFF_LOOP:    rd_word = loop_q;
      `PCP_OFF_FP_CTRL: rd_word = fp_q;
      `PCP_OFF_FP_MUL:  rd_word = 32'(fp_mul);
      `PCP_OFF_FP_DIV:  rd_word = 32'(fp_div);
      `PCP_OFF_VERSION: rd_word = version_word;
      default: begin
        for (int g = 0; g < NUM_GCLK; g++) begin
          if (araddr == pcp_gclk_addr(g)) begin
            rd_word = gclk_word[g];
          end
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= `PCP_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= pcp_known(araddr) ? `PCP_RESP_OKAY : `PCP_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  rejected_c: cover property (loop_wr_hit && !unlocked);

endmodule : pcp_clock_ctrl

//--- test/pcp_clock_ctrl_tb.sv
`include "pcp_params.svh"

module pcp_clock_ctrl_tb
  import pcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] OK = `PCP_RESP_OKAY;
  localparam logic [1:0] ER = `PCP_RESP_SLVERR;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, system_rc_oscillator_clk = 0, loop_vco_clk = 0;
  logic        sleep_active = 0, periph_clk_stop = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0, src_clk = '0;
  logic        awready, wready, bvalid, arready, rvalid, loop_power_on;
  logic        loop_range_high, loop_wideband_en, loop_clk_out;
  logic        lock_status_flag, frac_prescaled_clock_out;
  logic [1:0]  bresp, rresp, loop_ref_select;
  logic [31:0] rdata;
  logic [5:0]  loop_ratio_num;
  logic [3:0]  loop_ratio_den, gclk_out;
  int          error_cnt = 0, n_checks = 0, seed = 32'hc099;
  int          tg[4], rc_rises, hc, hmin, hmax;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [1:0]  ph = '0;
  logic [3:0]  prev_out = '0, cur;
  logic        rc_run = 0, prev_lock = 0, prev_rc = 0, hv = 0;

  pcp_clock_ctrl pcp_clock_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .src_clk(src_clk),
    .system_rc_oscillator_clk(system_rc_oscillator_clk), .loop_vco_clk(loop_vco_clk),
    .sleep_active(sleep_active), .periph_clk_stop(periph_clk_stop),
    .loop_power_on(loop_power_on), .loop_ref_select(loop_ref_select),
    .loop_range_high(loop_range_high), .loop_wideband_en(loop_wideband_en),
    .loop_ratio_num(loop_ratio_num), .loop_ratio_den(loop_ratio_den),
    .loop_clk_out(loop_clk_out), .lock_status_flag(lock_status_flag),
    .frac_prescaled_clock_out(frac_prescaled_clock_out),
    .gclk_out(gclk_out));

  // Ten megahertz bench clock.
  always #50 aclk = ~aclk;

  // Sources toggle every four cycles so the synchronisers never alias.
  always @(posedge aclk) begin
    ph <= ph + 2'd1;
    if (ph == 2'd3) begin
      src_clk      <= ~src_clk;
      loop_vco_clk <= ~loop_vco_clk;
      if (rc_run) begin
        system_rc_oscillator_clk <= ~system_rc_oscillator_clk;
      end
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Edge counts carry one count of slack for synchroniser phase.
  task automatic near(input string nm, input int e, input int g);
    n_checks++;
    if (g < e - 1 || g > e + 1) begin
      error_cnt++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : near

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // Bus answers are compared against the oldest note; the edge counters
  // and the masking watch run in the same process.
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready) begin
      chk("rdata", rq[0][31:0], rdata);
      chk("rresp", {30'd0, rq[0][33:32]}, {30'd0, rresp});
      void'(rq.pop_front());
    end
    if (bvalid === 1'b1 && bready) begin
      chk("bresp", {30'd0, bq.pop_front()}, {30'd0, bresp});
    end
    cur = {loop_clk_out, gclk_out[1:0], frac_prescaled_clock_out};
    hc++;
    for (int i = 0; i < 4; i++) begin
      if (cur[i] !== prev_out[i]) begin
        tg[i]++;
      end
    end
    if (cur[0] !== prev_out[0]) begin
      if (hv && hc < hmin) hmin = hc;
      if (hv && hc > hmax) hmax = hc;
      hv = 1;
      hc = 0;
    end
    if (system_rc_oscillator_clk && !prev_rc) rc_rises++;
    if (aresetn && loop_clk_out === 1'b1 && !lock_status_flag &&
        !prev_lock) begin
      error_cnt++;
      $display("[FAIL] loop_clk_out expected 0 seen 1");
    end
    prev_out  = cur;
    prev_rc   = system_rc_oscillator_clk;
    prev_lock = lock_status_flag;
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    bq.push_back(r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 60);
    bready <= 1'b0;
    if (n >= 60) chk("write answer", 1, 0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    rq.push_back({r, d});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 60);
    rready <= 1'b0;
    if (n >= 60) chk("read answer", 1, 0);
  endtask : rd

  // Unlock key followed at once by the loop control write.
  task automatic lwr(input pcp_loop_t v, input logic [1:0] r);
    wr(`PCP_OFF_UNLOCK, {`PCP_UNLOCK_KEY, 12'h000, `PCP_OFF_LOOP}, OK);
    wr(`PCP_OFF_LOOP, v, r);
  endtask : lwr

  task automatic wlock(input logic v);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (lock_status_flag !== v && n < 400);
    chk("lock_status_flag", v, lock_status_flag);
  endtask : wlock

  task automatic win(input int n);
    tg = '{default: 0};
    hv = 0;
    hmin = 100000;
    hmax = 0;
    repeat (n) @(posedge aclk);
  endtask : win

  // A hang ends the run through the same closing task.
  initial begin
    #(100 * 40000);
    error_cnt++;
    wrap_up();
  end

  initial begin
    pcp_loop_t lc;
    pcp_fp_t   fc;
    pcp_gclk_t gc;
    int        m;
    int        d;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PCP_OFF_LOOP, 32'h0000_0000, OK);
    rd(`PCP_OFF_VERSION, {12'h000, `PCP_VARIANT_NUM, 4'h0,
       `PCP_VERSION_NUM}, OK);
    wr(`PCP_OFF_VERSION, 32'hffff_ffff, OK);
    rd(`PCP_OFF_VERSION, {12'h000, `PCP_VARIANT_NUM, 4'h0,
       `PCP_VERSION_NUM}, OK);
    rd(12'h0f0, 32'h0000_0000, ER);
    lc = '0;
    lc.en = 1;
    lc.osc = 2;
    lc.opt = 3'b010;
    lc.div = 3;
    lc.mul = 5;
    lc.count = 3;
    wr(`PCP_OFF_LOOP, lc, ER);
    wr(`PCP_OFF_UNLOCK, {`PCP_UNLOCK_KEY, 12'h000, `PCP_OFF_LOOP}, OK);
    rd(`PCP_OFF_STATUS, 32'h0000_0004, OK);
    wr(`PCP_OFF_FP_DIV, 32'h0000_0004, OK);
    wr(`PCP_OFF_LOOP, lc, ER);
    rd(`PCP_OFF_LOOP, 32'h0000_0000, OK);
    chk("loop_power_on", 0, loop_power_on);
    lwr(lc, OK);
    rd(`PCP_OFF_LOOP, lc, OK);
    rc_rises = 0;
    win(20);
    chk("lock_status_flag", 0, lock_status_flag);
    chk("loop_power_on", 1, loop_power_on);
    chk("loop_ref_select", 2, loop_ref_select);
    chk("loop_range_high", 0, loop_range_high);
    chk("loop_wideband_en", 1, loop_wideband_en);
    chk("loop_ratio", {6'd6, 4'd3}, {loop_ratio_num, loop_ratio_den});
    rc_run <= 1'b1;
    wlock(1);
    chk("rc edges before lock", 1, rc_rises >= 3);
    rd(`PCP_OFF_STATUS, 32'h0000_0003, OK);
    win(128);
    near("loop_clk_out toggles", 16, tg[3]);
    lc.div = 0;
    lc.mul = 2;
    lc.opt = 3'b101;
    lc.osc = 1;
    lwr(lc, OK);
    win(3);
    chk("lock_status_flag", 0, lock_status_flag);
    chk("loop_ratio", {6'd6, 4'd1}, {loop_ratio_num, loop_ratio_den});
    chk("loop_range_high", 1, loop_range_high);
    chk("loop_wideband_en", 0, loop_wideband_en);
    chk("loop_ref_select", 1, loop_ref_select);
    wlock(1);
    sleep_active <= 1'b1;
    win(4);
    chk("loop_power_on", 0, loop_power_on);
    chk("lock_status_flag", 0, lock_status_flag);
    sleep_active <= 1'b0;
    wlock(1);
    lc.en = 0;
    lwr(lc, OK);
    win(4);
    chk("loop_power_on", 0, loop_power_on);
    chk("lock_status_flag", 0, lock_status_flag);
    m = ($random(seed) & 3) + 1;
    fc = '0;
    fc.en = 1;
    fc.sel = 1;
    wr(`PCP_OFF_FP_MUL, m, OK);
    wr(`PCP_OFF_FP_CTRL, fc, OK);
    fc.sel = 3;
    wr(`PCP_OFF_FP_CTRL, fc, OK);
    rd(`PCP_OFF_FP_CTRL, 32'h0000_0003, OK);
    win(512);
    near("prescaler toggles", 16 * m, tg[0]);
    chk("half period spread", 1, hmax - hmin <= 8);
    chk("jitter seen", 4 % m != 0, hmax != hmin);
    wr(`PCP_OFF_FP_MUL, 32'h0000_0004, OK);
    win(512);
    near("prescaler toggles", 64, tg[0]);
    d = ($random(seed) & 3) + 1;
    gc = '0;
    gc.en = 1;
    gc.div_en = 1;
    gc.src = 2;
    gc.div = d;
    wr(`PCP_OFF_GCLK, gc, OK);
    wr(`PCP_OFF_GCLK + `PCP_GCLK_STRIDE, 32'h0000_0001, OK);
    win(512);
    near("divided gclk toggles", 64 / (d + 1), tg[1]);
    near("undivided gclk toggles", 128, tg[2]);
    periph_clk_stop <= 1'b1;
    win(4);
    win(64);
    chk("gclk_out", 0, gclk_out);
    near("stopped gclk toggles", 0, tg[1] + tg[2]);
    periph_clk_stop <= 1'b0;
    wr(`PCP_OFF_GCLK + `PCP_GCLK_STRIDE, 32'h0000_0000, OK);
    win(4);
    win(128);
    near("disabled gclk toggles", 0, tg[2]);
    chk("running gclk", 1, tg[1] > 1);
    gc.div = 8'hff;
    wr(`PCP_OFF_GCLK, gc, OK);
    win(4200);
    near("max ratio gclk toggles", 2, tg[1]);
    wrap_up();
  end

endmodule : pcp_clock_ctrl_tb
